// ### hw/dcu_pkg.sv
// package for the unit-select and controller status register bank
// assumes one 100 MHz core clock; bit numbers are MSB-first (bit 0 is vector [15])
package dcu_pkg;
    localparam int unsigned WORD_W        = 16;            // control word width
    localparam logic [2:0]  CW_UNIT_SEL   = 3'h6;          // unit select / address high
    localparam logic [2:0]  CW_STATUS     = 3'h7;          // controller status/control
    // msb-first bit numbers mapped to vector indices (bit n -> [15-n])
    localparam int unsigned B_IDLE        = 15;            // bit 0
    localparam int unsigned B_COMPLETE    = 14;            // bit 1
    localparam int unsigned B_ERROR       = 13;            // bit 2
    localparam int unsigned B_DONE_IE     = 12;            // bit 3, completion irq enable
    localparam int unsigned B_LOCK        = 11;            // bit 4
    localparam int unsigned B_REREAD      = 10;            // bit 5
    localparam int unsigned B_ECC         = 9;             // bit 6
    localparam int unsigned B_ABNORMAL    = 8;             // bit 7
    localparam int unsigned B_MEMFAULT    = 7;             // bit 8
    localparam int unsigned B_UNCORR      = 6;             // bit 9
    localparam int unsigned B_NORESP      = 5;             // bit 10
    localparam int unsigned B_HDRMISS     = 4;             // bit 11
    localparam int unsigned B_RATE        = 3;             // bit 12
    localparam int unsigned B_TIMEOUT     = 2;             // bit 13
    localparam int unsigned B_SYNCMISS    = 1;             // bit 14
    localparam int unsigned B_DRVFAULT    = 0;             // bit 15
    localparam logic [15:0] SEL_MASK      = 16'h0f00;      // bits 4..7
    localparam logic [15:0] ADDR_HI_MASK  = 16'h001f;      // bits 11..15
    localparam logic [15:0] SELFTEST_ERR  = 16'h00ff;      // bits 8..15
    localparam logic [15:0] STATUS_RST    = 16'h8000;      // idle, all else clear
    localparam logic [15:0] UNIT_RST      = 16'h0000;      // nothing selected
    localparam logic [15:0] UNFMT_MAX_CNT = 16'h01fe;      // 510 bytes
    localparam int unsigned TIMEOUT_CYC   = 100000;        // default command limit
    typedef enum logic [0:0] {
        DCU_IDLE = 1'b0,                                   // waiting for a command
        DCU_BUSY = 1'b1                                    // command running
    } dcu_state_e;
endpackage : dcu_pkg

// ### hw/dcu_cmd_timer.sv
// command time-out counter for the status bank
// assumes run is a level input on core_clk
module dcu_cmd_timer
    import dcu_pkg::*;
#(
    parameter int unsigned LIMIT = TIMEOUT_CYC   // cycles allowed per command
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      expired
);
    logic [31:0] cnt_ff;                         // elapsed cycles
    logic [31:0] nxt_cnt;

    // counts while run is high, restarts when run drops
    always_comb begin
        nxt_cnt = cnt_ff;
        if (!run) begin
            nxt_cnt = 32'h0;
        end else if (cnt_ff < LIMIT) begin
            nxt_cnt = cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 32'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign expired = run && (cnt_ff == LIMIT - 1);

    chk_timer_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
        !run |=> cnt_ff == 32'h0) else $error("timer not restarted");
endmodule // dcu_cmd_timer

// ### hw/dcu_status_bank.sv
// unit-select/address-high and status/control words of a disk controller
// assumes a word-wide host port: addr picks word, rd/wr are one-cycle strobes,
// and a command engine reports progress and end-of-command events
// Function
// - one-hot select bits choose drive unit
// - upper five address bits, updated during transfer
// - low address word joins upper five bits
// - idle bit readable always; full access only idle
// - busy read returns four status bits only
// - command end sets complete or error bit
// - software may set or clear completion bits
// - completion interrupt when idle, done, enabled
// - enabling with done already set interrupts
// - attention interrupt independent of completion enable
// - attention interrupt when idle, ready, masked in
// - status read sets lock; reset, end clear
// - re-read during read sets reread flag
// - correction sets ecc flag, counted in log
// - self-test failure sets all error bits
// - reset or power warning ends, sets abnormal
// - memory fault and no-response set their flags
// - uncorrectable read sets its flag
// - header mismatch sets flag, ends command
// - rate bit only set by self-test
// - time-out or unformatted count over 510
// - missing sync sets flag, ends command
// - drive fault sets flag, ends command
module dcu_status_bank
    import dcu_pkg::*;
#(
    parameter int unsigned CMD_LIMIT = dcu_pkg::TIMEOUT_CYC  // command time limit
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [2:0]  addr,           // control word number
    input  wire logic        rd,             // read strobe
    input  wire logic        wr,             // write strobe
    input  wire logic [15:0] wdata,          // write data
    output logic      [15:0] rdata,          // read data
    input  wire logic        slave_en,       // busy readback bit 1
    input  wire logic        ctrl_bad,       // busy readback bit 2
    input  wire logic        err_code,       // busy readback bit 3
    input  wire logic        power_warn,     // io reset or power-fail warning
    input  wire logic        addr_step,      // engine advances address high
    input  wire logic [4:0]  addr_hi_in,     // new address high bits
    input  wire logic        cmd_end,        // engine finished a command
    input  wire logic        ev_reread,      // sector re-read
    input  wire logic        ev_ecc,         // sector corrected
    input  wire logic        ev_selftest,    // self-test failed
    input  wire logic        ev_memfault,    // memory error
    input  wire logic        ev_uncorr,      // uncorrectable read
    input  wire logic        ev_noresp,      // memory not answering
    input  wire logic        ev_hdrmiss,     // header not found
    input  wire logic        ev_syncmiss,    // sync not found
    input  wire logic        ev_drvfault,    // drive error
    input  wire logic        unfmt_cmd,      // command being started is unformatted
    input  wire logic [15:0] byte_count,     // current byte count word
    input  wire logic [3:0]  attn_ready,     // per-unit attention ready
    input  wire logic [3:0]  attn_mask,      // per-unit attention mask bits
    output logic [3:0]       drive_select,   // one-hot unit select
    output logic [4:0]       addr_hi,        // start address high bits
    output logic             cmd_start,      // pulse: command launched
    output logic             cmd_abort,      // pulse: engine must terminate
    output logic             done_irq,       // completion interrupt
    output logic             attn_irq,       // attention interrupt
    output logic [15:0]      ecc_log         // count of corrected sectors
);
    dcu_state_e  state_ff, nxt_state;        // idle / busy
    logic [15:0] unit_ff, nxt_unit;          // unit select word
    logic [15:0] stat_ff, nxt_stat;          // status word
    logic [15:0] rdata_ff, nxt_rdata;        // read data register
    logic [15:0] ecc_ff, nxt_ecc;            // ecc log counter
    logic        start_ff, nxt_start;        // start pulse
    logic        abort_ff, nxt_abort;        // abort pulse
    logic        tmo;                        // time-out expiry
    logic        idle;                       // idle view
    logic        stat_wr, unit_wr;           // decoded writes
    logic        err_now;                    // error seen this cycle
    logic        end_now;                    // command ends this cycle

    assign idle    = (state_ff == DCU_IDLE);
    assign stat_wr = wr && (addr == CW_STATUS);
    assign unit_wr = wr && (addr == CW_UNIT_SEL) && idle;   // busy writes dropped

    // time limit for running commands
    // run is the busy view, so every new command rearms the count
    dcu_cmd_timer #(.LIMIT(CMD_LIMIT)) u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .run      (!idle),
        .expired  (tmo)
    );

    // unit select word: software writes when idle, engine updates address
    always_comb begin
        nxt_unit = unit_ff;
        if (unit_wr) begin
            // unused bits kept as written; software owns zeros there
            nxt_unit = wdata;
        end else if (addr_step) begin
            nxt_unit = (unit_ff & ~ADDR_HI_MASK) | {11'h0, addr_hi_in};
        end
    end

    // status word, state and pulses
    always_comb begin
        nxt_state = state_ff;
        nxt_stat  = stat_ff;
        nxt_start = 1'b0;
        nxt_abort = 1'b0;
        nxt_ecc   = ecc_ff;
        err_now   = 1'b0;
        end_now   = 1'b0;
        // software writes first so hardware events below win
        if (stat_wr) begin
            if (idle) begin
                nxt_stat = wdata;
                // only a status read or a command end moves the lock bit
                nxt_stat[B_LOCK] = stat_ff[B_LOCK];
                if (!wdata[B_IDLE]) begin
                    // clearing idle starts a command
                    nxt_state = DCU_BUSY;
                    nxt_start = 1'b1;
                    nxt_stat[B_IDLE] = 1'b0;
                    nxt_stat[B_LOCK] = stat_ff[B_LOCK];
                    nxt_stat[B_REREAD] = 1'b0;
                    nxt_stat[B_ECC] = 1'b0;
                    nxt_stat[B_ABNORMAL:B_DRVFAULT] = 9'h0;
                end
            end else begin
                // only the completion bits accept busy writes
                nxt_stat[B_COMPLETE] = wdata[B_COMPLETE];
                nxt_stat[B_ERROR]    = wdata[B_ERROR];
            end
        end
        if (rd && addr == CW_STATUS) begin
            nxt_stat[B_LOCK] = 1'b1;
        end
        if (nxt_start && unfmt_cmd && byte_count > UNFMT_MAX_CNT) begin
            nxt_stat[B_TIMEOUT] = 1'b1;
            err_now = 1'b1;
            end_now = 1'b1;
        end
        if (!idle) begin
            if (ev_reread) nxt_stat[B_REREAD] = 1'b1;
            if (ev_ecc) begin
                nxt_stat[B_ECC] = 1'b1;
                nxt_ecc = ecc_ff + 16'h1;
            end
            if (ev_uncorr) begin
                nxt_stat[B_UNCORR] = 1'b1;
                err_now = 1'b1;
            end
            if (ev_memfault) begin
                nxt_stat[B_MEMFAULT] = 1'b1;
                err_now = 1'b1;
                end_now = 1'b1;
            end
            if (ev_noresp) begin
                nxt_stat[B_NORESP] = 1'b1;
                err_now = 1'b1;
                end_now = 1'b1;
            end
            if (ev_hdrmiss) begin
                nxt_stat[B_HDRMISS] = 1'b1;
                err_now = 1'b1;
                end_now = 1'b1;
            end
            if (ev_syncmiss) begin
                nxt_stat[B_SYNCMISS] = 1'b1;
                err_now = 1'b1;
                end_now = 1'b1;
            end
            if (ev_drvfault) begin
                nxt_stat[B_DRVFAULT] = 1'b1;
                err_now = 1'b1;
                end_now = 1'b1;
            end
            if (tmo) begin
                nxt_stat[B_TIMEOUT] = 1'b1;
                err_now = 1'b1;
                end_now = 1'b1;
            end
            if (power_warn) begin
                nxt_stat[B_ABNORMAL] = 1'b1;
                err_now = 1'b1;
                end_now = 1'b1;
            end
            if (cmd_end) begin
                end_now = 1'b1;
            end
        end
        // self-test failure fills the whole error field; rate bit only here
        if (ev_selftest) begin
            nxt_stat = nxt_stat | SELFTEST_ERR;
            err_now = 1'b1;
        end
        if (end_now) begin
            // error bits latched earlier in the command still mean an error end
            // exactly one completion bit per command
            nxt_stat[B_COMPLETE] = !(err_now || (|stat_ff[B_MEMFAULT:B_DRVFAULT]));
            nxt_stat[B_ERROR]    = err_now || (|stat_ff[B_MEMFAULT:B_DRVFAULT]);
            nxt_stat[B_LOCK]     = 1'b0;
            nxt_stat[B_IDLE]     = 1'b1;
            nxt_state = DCU_IDLE;
            nxt_abort = !cmd_end;
        end
    end

    // read data: full word when idle, four bits when busy
    always_comb begin
        nxt_rdata = rdata_ff;
        if (rd) begin
            if (idle) begin
                unique case (addr)
                    CW_UNIT_SEL: nxt_rdata = unit_ff;
                    CW_STATUS:   nxt_rdata = stat_ff;
                    // words this bank does not own read as zero
                    default:     nxt_rdata = 16'h0;
                endcase
            end else begin
                nxt_rdata = {1'b0, slave_en, ctrl_bad, err_code, 12'h0};
            end
        end
    end

    // registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= DCU_IDLE;
            unit_ff  <= UNIT_RST;
            stat_ff  <= STATUS_RST;
            rdata_ff <= 16'h0;
            ecc_ff   <= 16'h0;
            start_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            unit_ff  <= nxt_unit;
            stat_ff  <= nxt_stat;
            rdata_ff <= nxt_rdata;
            ecc_ff   <= nxt_ecc;
            start_ff <= nxt_start;
            abort_ff <= nxt_abort;
        end
    end

    assign rdata        = rdata_ff;
    // msb-first bit 4 is unit 0, so the select field is read back to front
    for (genvar u = 0; u < 4; u++) begin : g_sel
        assign drive_select[u] = unit_ff[B_IDLE - 4 - u];
    end
    assign addr_hi      = unit_ff[4:0];                            // joins low word
    assign cmd_start    = start_ff;
    assign cmd_abort    = abort_ff;
    assign ecc_log      = ecc_ff;
    // completion interrupt
    assign done_irq = stat_ff[B_IDLE] && (stat_ff[B_COMPLETE] || stat_ff[B_ERROR])
                      && stat_ff[B_DONE_IE];
    // attention interrupt, no completion enable term
    assign attn_irq = idle && |(attn_ready & attn_mask);

    // checks next to the logic they guard
    chk_done_irq_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
        done_irq |-> stat_ff[B_DONE_IE] && idle) else $error("irq without cause");
    chk_enable_immediate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (idle && stat_wr && wdata[B_IDLE] && wdata[B_DONE_IE] && wdata[B_COMPLETE])
        |=> done_irq) else $error("enable did not interrupt");
    chk_attn_no_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
        (idle && (attn_ready[0] && attn_mask[0])) |-> attn_irq)
        else $error("attention blocked");
    chk_lock_on_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rd && addr == CW_STATUS && !end_now) |=> stat_ff[B_LOCK])
        else $error("lock not set");
    chk_busy_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rd && !idle) |=> rdata[15] == 1'b0 && rdata[11:0] == 12'h0)
        else $error("busy readback wrong");
    chk_one_done_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!idle && end_now && !stat_wr) |=> stat_ff[B_COMPLETE] != stat_ff[B_ERROR])
        else $error("completion bits wrong");
    chk_selftest_all: assert property (@(posedge core_clk) disable iff (!rst_n)
        ev_selftest |=> (stat_ff & SELFTEST_ERR) == SELFTEST_ERR)
        else $error("self-test bits missing");
    chk_busy_unit_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!idle && !addr_step) |=> $stable(unit_ff))
        else $error("unit word changed while busy");
    chk_abnormal_end: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!idle && power_warn && !cmd_end) |=> idle && stat_ff[B_ABNORMAL] && cmd_abort)
        else $error("power warning not handled");
    chk_hdr_ends: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!idle && ev_hdrmiss && !cmd_end) |=> idle && cmd_abort)
        else $error("header miss did not end");
    chk_unfmt_reject: assert property (@(posedge core_clk) disable iff (!rst_n)
        (idle && stat_wr && !wdata[B_IDLE] && unfmt_cmd && byte_count > UNFMT_MAX_CNT)
        |=> idle && stat_ff[B_TIMEOUT] && stat_ff[B_ERROR] && cmd_abort)
        else $error("oversized unformatted count not refused");

    // main scenarios worth seeing in a run
    cov_cmd_ok:    cover property (@(posedge core_clk) cmd_start ##[1:50] cmd_end);
    cov_unfmt_rej: cover property (@(posedge core_clk) cmd_start && cmd_abort);
    cov_done_irq:  cover property (@(posedge core_clk) $rose(done_irq));
    cov_attn_irq:  cover property (@(posedge core_clk) $rose(attn_irq));
    cov_busy_read: cover property (@(posedge core_clk) rd && !idle);
endmodule // dcu_status_bank

// ### dv/dcu_host_model.sv
// host processor model: word reads and writes on the status bank port
// assumes one-cycle rd/wr strobes and rdata registered after the strobe
module dcu_host_model
    import dcu_pkg::*;
(
    input  wire logic        core_clk,   // core clock
    output logic      [2:0]  addr,       // word number
    output logic             rd,         // read strobe
    output logic             wr,         // write strobe
    output logic      [15:0] wdata,      // write data
    input  wire logic [15:0] rdata       // read data
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet port at time zero
    initial begin
        addr  = 3'h0;
        rd    = 1'b0;
        wr    = 1'b0;
        wdata = 16'h0000;
    end
    // one write strobe; unused unit-select bits always go out as zero
    task automatic write_word(input logic [2:0] a, input logic [15:0] d);
        @(negedge core_clk);
        addr  = a;
        wdata = (a == CW_UNIT_SEL) ? (d & (SEL_MASK | ADDR_HI_MASK)) : d;
        wr    = 1'b1;
        @(negedge core_clk);
        wr    = 1'b0;
        addr  = ~addr;   // released lines must not keep the old value
        wdata = ~wdata;
    endtask
    // one read strobe; data taken a full cycle after the strobe edge
    task automatic read_word(input logic [2:0] a, output logic [15:0] d);
        @(negedge core_clk);
        addr = a;
        rd   = 1'b1;
        @(negedge core_clk);
        rd   = 1'b0;
        addr = ~addr;
        @(negedge core_clk);
        d = rdata;
    endtask
endmodule // dcu_host_model

// ### dv/testbench.sv
// self-checking bench for the unit-select and status register bank
// assumes the host model drives the word port; the bench plays the command engine
module testbench
    import dcu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned LIM = 60;      // shortened command time limit
    typedef struct packed {
        logic [15:0] wd;                   // unit word written
        logic [3:0]  sel;                  // one-hot unit expected
    } dcu_row_s;
    logic        core_clk = 1'b0;          // 100 MHz core clock
    logic        rst_n    = 1'b0;          // active-low reset
    wire  [2:0]  addr;                     // host word number
    wire         rd;                       // host read strobe
    wire         wr;                       // host write strobe
    wire  [15:0] wdata;                    // host write data
    logic [15:0] rdata;                    // read data
    logic        slave_en, ctrl_bad, err_code;
    logic        unfmt_cmd;                // unformatted command flag
    logic [15:0] byte_count;               // byte count word
    logic [3:0]  attn_ready, attn_mask;    // attention lines and mask
    logic [4:0]  addr_hi_in;               // engine address high
    logic [11:0] ev = 12'h000;             // engine event pulses
    logic [3:0]  drive_select;
    logic [4:0]  addr_hi;
    logic        cmd_start, cmd_abort, done_irq, attn_irq;
    logic [15:0] ecc_log;
    logic [15:0] rv;                       // last word read
    int          failures, num_checks;
    dcu_row_s    rows [5] = '{'{16'h0800, 4'h1}, '{16'h0403, 4'h2}, '{16'h0201, 4'h4},
                              '{16'h011f, 4'h8}, '{16'h0000, 4'h0}};
    int          err_ev  [6] = '{3, 4, 5, 6, 7, 8};
    logic [15:0] err_bit [6] = '{16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0002, 16'h0001};
    // free-running core clock
    always #5 core_clk = ~core_clk;
    dcu_host_model host_inst (.core_clk(core_clk), .addr(addr), .rd(rd), .wr(wr),
        .wdata(wdata), .rdata(rdata));
    dcu_status_bank #(.CMD_LIMIT(LIM)) dcu_status_bank_inst (
        .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .rd(rd), .wr(wr),
        .wdata(wdata), .rdata(rdata), .slave_en(slave_en), .ctrl_bad(ctrl_bad),
        .err_code(err_code), .power_warn(ev[10]), .addr_step(ev[11]),
        .addr_hi_in(addr_hi_in), .cmd_end(ev[9]), .ev_reread(ev[0]), .ev_ecc(ev[1]),
        .ev_selftest(ev[2]), .ev_memfault(ev[3]), .ev_uncorr(ev[4]), .ev_noresp(ev[5]),
        .ev_hdrmiss(ev[6]), .ev_syncmiss(ev[7]), .ev_drvfault(ev[8]),
        .unfmt_cmd(unfmt_cmd), .byte_count(byte_count), .attn_ready(attn_ready),
        .attn_mask(attn_mask), .drive_select(drive_select), .addr_hi(addr_hi),
        .cmd_start(cmd_start), .cmd_abort(cmd_abort), .done_irq(done_irq),
        .attn_irq(attn_irq), .ecc_log(ecc_log));
    // verdict and end of run
    task automatic finish_test();
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // masked compare of a seen word against its expected value
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input logic [15:0] m);
        num_checks++;
        if ((seen & m) !== (exp & m)) begin
            failures++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle engine event
    task automatic pulse(input int i);
        @(negedge core_clk);
        ev[i] = 1'b1;
        @(negedge core_clk);
        ev[i] = 1'b0;
    endtask
    // start a command and see the launch pulse within a bound
    task automatic start_cmd(input logic [15:0] d);
        host_inst.write_word(CW_STATUS, d);
        for (int n = 0; n < 3 && cmd_start !== 1'b1; n++) @(negedge core_clk);
        check({15'h0, cmd_start}, 16'h1, 16'hffff);
    endtask
    // poll the status word until idle, bounded
    task automatic wait_idle();
        for (int n = 0; n < 40; n++) begin
            host_inst.read_word(CW_STATUS, rv);
            if (rv[B_IDLE] === 1'b1) return;
        end
        failures++;
        finish_test();
    endtask
    // main sequence
    initial begin
        {slave_en, ctrl_bad, err_code} = 3'b101;
        unfmt_cmd  = 1'b0;
        byte_count = 16'h0000;
        attn_ready = 4'h0;
        attn_mask  = 4'h0;
        addr_hi_in = 5'h00;
        failures   = 0;
        num_checks = 0;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        host_inst.read_word(CW_STATUS, rv);
        check(rv, STATUS_RST, 16'hf7ff);
        // unit select rows: one-hot unit and address high
        foreach (rows[i]) begin
            host_inst.write_word(CW_UNIT_SEL, rows[i].wd);
            host_inst.read_word(CW_UNIT_SEL, rv);
            check(rv, rows[i].wd, 16'hffff);
            check({12'h0, drive_select}, {12'h0, rows[i].sel}, 16'hffff);
            check({11'h0, addr_hi}, rows[i].wd & ADDR_HI_MASK, 16'hffff);
        end
        host_inst.read_word(3'h3, rv);
        check(rv, 16'h0000, 16'hffff);
        // normal command with busy read-back and refused writes
        host_inst.write_word(CW_UNIT_SEL, 16'h0403);
        start_cmd(16'h1000);
        host_inst.read_word(CW_UNIT_SEL, rv);
        check(rv, 16'h5000, 16'hffff);
        host_inst.write_word(CW_UNIT_SEL, 16'h0800);
        host_inst.write_word(CW_STATUS, 16'h8000);
        host_inst.read_word(CW_STATUS, rv);
        check(rv, 16'h5000, 16'hffff);
        check({12'h0, drive_select}, 16'h0002, 16'hffff);
        attn_ready = 4'h2;
        attn_mask  = 4'h2;
        addr_hi_in = 5'h15;
        @(negedge core_clk);
        check({15'h0, attn_irq}, 16'h0, 16'hffff);
        pulse(11);
        pulse(0);
        pulse(1);
        pulse(9);
        wait_idle();
        host_inst.read_word(CW_STATUS, rv);
        check(rv, 16'hde00, 16'hffff);
        check({11'h0, addr_hi}, 16'h0015, 16'hffff);
        check(ecc_log, 16'h0001, 16'hffff);
        check({14'h0, done_irq, attn_irq}, 16'h3, 16'hffff);
        // software handling of the completion bits and the enable
        host_inst.write_word(CW_STATUS, 16'h9000);
        @(negedge core_clk);
        check({15'h0, done_irq}, 16'h0, 16'hffff);
        host_inst.write_word(CW_STATUS, 16'hd000);
        @(negedge core_clk);
        check({15'h0, done_irq}, 16'h1, 16'hffff);
        host_inst.write_word(CW_STATUS, 16'hc000);
        @(negedge core_clk);
        check({14'h0, done_irq, attn_irq}, 16'h1, 16'hffff);
        attn_mask = 4'h1;
        @(negedge core_clk);
        check({15'h0, attn_irq}, 16'h0, 16'hffff);
        // each error event ends with the error bit and its own flag
        foreach (err_ev[i]) begin
            start_cmd(16'h0000);
            pulse(err_ev[i]);
            repeat (3) @(negedge core_clk);
            host_inst.read_word(CW_STATUS, rv);
            if (rv[B_IDLE] !== 1'b1) pulse(9);
            wait_idle();
            host_inst.read_word(CW_STATUS, rv);
            check(rv, 16'ha800 | err_bit[i], 16'hffff);
        end
        // command time limit
        start_cmd(16'h0000);
        for (int n = 0; n < 100 && cmd_abort !== 1'b1; n++) @(negedge core_clk);
        check({15'h0, cmd_abort}, 16'h1, 16'hffff);
        wait_idle();
        host_inst.read_word(CW_STATUS, rv);
        check(rv, 16'ha804, 16'hffff);
        // unformatted byte count at and above the limit
        unfmt_cmd  = 1'b1;
        byte_count = UNFMT_MAX_CNT;
        start_cmd(16'h0000);
        host_inst.read_word(CW_STATUS, rv);
        check(rv, 16'h0000, 16'h8000);
        pulse(9);
        wait_idle();
        byte_count = 16'h0200;
        start_cmd(16'h0000);
        wait_idle();
        host_inst.read_word(CW_STATUS, rv);
        check(rv, 16'ha804, 16'hffff);
        unfmt_cmd = 1'b0;
        // self-test failure report while idle
        pulse(2);
        host_inst.read_word(CW_STATUS, rv);
        check(rv, SELFTEST_ERR, 16'h00ff);
        // power warning ends a running command abnormally
        start_cmd(16'h0000);
        pulse(10);
        wait_idle();
        host_inst.read_word(CW_STATUS, rv);
        check(rv, 16'ha900, 16'hff00);
        // second reset in mid-run
        @(negedge core_clk);
        rst_n = 1'b0;
        @(negedge core_clk);
        rst_n = 1'b1;
        host_inst.read_word(CW_STATUS, rv);
        check(rv, STATUS_RST, 16'hf7ff);
        check({11'h0, done_irq, drive_select}, 16'h0, 16'hffff);
        finish_test();
    end
endmodule // testbench
